// *** logic/dam_address_modes.sv ***
// address generator mode logic: circular, broadcast, bit-reverse, simd
// assumes one access request per cycle from the load/store datapath
// and a register port driven by the core on the same clock
`timescale 1ns/1ps
`include "dam_defs.svh"
module dam_address_modes (
   input  wire logic                 i_clk,      // core clock
   input  wire logic                 i_nrst,     // sync reset, low
   input  wire logic [`DAM_AW-1:0]   i_addr,     // register word index
   input  wire logic [`DAM_DW-1:0]   i_wdata,    // register write data
   input  wire logic                 i_wr,       // register write strobe
   input  wire logic                 i_rd,       // register read strobe
   output logic      [`DAM_DW-1:0]   o_rdata,    // read data, next cycle
   input  wire logic                 i_acc,      // access request
   input  wire logic                 i_acc_gen,  // 0 gen a, 1 gen b
   input  wire logic [2:0]           i_acc_idx,  // index within gen
   input  wire logic [2:0]           i_acc_msel, // modify within gen
   input  wire logic                 i_acc_imm,  // use immediate
   input  wire logic [`DAM_DW-1:0]   i_acc_ival, // immediate modifier
   input  wire logic                 i_acc_rd,   // memory read
   input  wire logic                 i_acc_dreg, // data register target
   output logic                      o_mvalid,   // explicit transfer
   output logic                      o_mread,    // transfer is a read
   output logic      [`DAM_DW-1:0]   o_maddr,    // explicit address
   output logic                      o_pvalid,   // implicit transfer
   output logic      [`DAM_DW-1:0]   o_paddr,    // implicit address
   output logic                      o_bcast,    // same data to both
   output logic      [`DAM_MODE_W-1:0] o_mode    // mode control one
);
   dam_pkg::dam_state_type r;
   dam_pkg::dam_state_type next_r;

   logic [`DAM_SELW-1:0] asel;
   logic [`DAM_SELW-1:0] msel;
   logic [`DAM_SELW-1:0] wsel;
   logic [`DAM_DW-1:0]   cur_idx;
   logic [`DAM_DW-1:0]   cur_mod;
   logic [`DAM_DW-1:0]   cur_len;
   logic [`DAM_DW-1:0]   cur_bas;
   logic [`DAM_DW-1:0]   rev_idx;
   logic [`DAM_DW-1:0]   new_idx;
   logic [`DAM_DW-1:0]   w_bas;
   logic                 use_rev;
   logic                 use_bc;
   logic                 wr_idx;
   logic                 wr_mod;
   logic                 wr_len;
   logic                 wr_bas;
   logic                 wr_mode;
   logic                 circ;

   // selects: modifier comes from the same generator, any number
   always_comb begin
      asel    = {i_acc_gen, i_acc_idx};
      msel    = {i_acc_gen, i_acc_msel};
      wsel    = i_addr[`DAM_SELW-1:0];
      cur_idx = r.idx[asel];
      cur_len = r.len[asel];
      cur_bas = r.bas[asel];
      w_bas   = r.bas[wsel];
      cur_mod = i_acc_imm ? i_acc_ival : r.mdf[msel];
      rev_idx = {<<{cur_idx}};
      circ    = r.mode[`DAM_MB_CIRC];
   end

   // special-index decode for bit-reverse and broadcast
   always_comb begin
      use_rev = (asel == `DAM_BR_A_IDX && r.mode[`DAM_MB_BRA])
             || (asel == `DAM_BR_B_IDX && r.mode[`DAM_MB_BRB]);
      use_bc  = ((asel == `DAM_BC_A_IDX && r.mode[`DAM_MB_BCA])
             || (asel == `DAM_BC_B_IDX && r.mode[`DAM_MB_BCB]))
             && i_acc_rd && i_acc_dreg;
   end

   // register port decode
   always_comb begin
      wr_idx  = i_wr && (i_addr[`DAM_AW-1:`DAM_SELW]
                == `DAM_OFS_IDX >> `DAM_SELW);
      wr_mod  = i_wr && (i_addr[`DAM_AW-1:`DAM_SELW]
                == `DAM_OFS_MOD >> `DAM_SELW);
      wr_len  = i_wr && (i_addr[`DAM_AW-1:`DAM_SELW]
                == `DAM_OFS_LEN >> `DAM_SELW);
      wr_bas  = i_wr && (i_addr[`DAM_AW-1:`DAM_SELW]
                == `DAM_OFS_BAS >> `DAM_SELW);
      wr_mode = i_wr && (i_addr == `DAM_OFS_MODE);
   end

   // post-modify arithmetic with wraparound
   dam_circ_step #(
      .DW (`DAM_DW)
   ) u_step (
      .i_idx  (cur_idx),
      .i_mod  (cur_mod),
      .i_len  (cur_len),
      .i_bas  (cur_bas),
      .i_circ (circ),
      .o_idx  (new_idx)
   );

   // next-state: access first, register writes override last
   always_comb begin
      next_r        = r;
      next_r.rdata  = '0;
      next_r.mvalid = 1'b0;
      next_r.pvalid = 1'b0;
      next_r.bcast  = 1'b0;
      next_r.mread  = 1'b0;
      if (i_acc) begin
         // old index (maybe reversed) drives the bus
         next_r.mvalid   = 1'b1;
         next_r.mread    = i_acc_rd;
         next_r.maddr    = use_rev ? rev_idx : cur_idx;
         next_r.idx[asel] = new_idx;
         // second transfer: broadcast copies, simd takes neighbour
         if (use_bc) begin
            next_r.bcast  = 1'b1;
            next_r.pvalid = 1'b1;
            next_r.paddr  = use_rev ? rev_idx : cur_idx;
         end else if (r.mode[`DAM_MB_SIMD]) begin
            next_r.pvalid = 1'b1;
            next_r.paddr  = (use_rev ? rev_idx : cur_idx)
                            + `DAM_PAIR_STEP;
         end
      end
      if (wr_idx) begin
         next_r.idx[wsel] = i_wdata;
      end
      if (wr_mod) begin
         next_r.mdf[wsel] = i_wdata;
      end
      if (wr_len) begin
         next_r.len[wsel] = i_wdata;
      end
      if (wr_bas) begin
         next_r.bas[wsel] = i_wdata;
         next_r.idx[wsel] = i_wdata;
      end
      if (wr_mode) begin
         next_r.mode = i_wdata[`DAM_MODE_W-1:0];
      end
      // read mux, unmapped words read zero
      if (i_rd) begin
         unique case (i_addr[`DAM_AW-1:`DAM_SELW])
            `DAM_OFS_IDX >> `DAM_SELW: next_r.rdata = r.idx[wsel];
            `DAM_OFS_MOD >> `DAM_SELW: next_r.rdata = r.mdf[wsel];
            `DAM_OFS_LEN >> `DAM_SELW: next_r.rdata = r.len[wsel];
            `DAM_OFS_BAS >> `DAM_SELW: next_r.rdata = r.bas[wsel];
            default: begin
               if (i_addr == `DAM_OFS_MODE) begin
                  next_r.rdata = {{(`DAM_DW-`DAM_MODE_W){1'b0}}, r.mode};
               end
            end
         endcase
      end
   end

   // state register, mode clears on reset
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         r      <= '0;
         r.mode <= `DAM_MODE_RST;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state
   assign o_rdata  = r.rdata;
   assign o_mvalid = r.mvalid;
   assign o_mread  = r.mread;
   assign o_maddr  = r.maddr;
   assign o_pvalid = r.pvalid;
   assign o_paddr  = r.paddr;
   assign o_bcast  = r.bcast;
   assign o_mode   = r.mode;

   // checks on the addressing behaviour
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_base_loads_idx: assert property (
      wr_bas |=> r.idx[$past(wsel)] == $past(i_wdata)
   ) else $error("base write did not load index");

   a_idx_keeps_base: assert property (
      wr_idx && !wr_bas |=> r.bas[$past(wsel)] == $past(w_bas)
   ) else $error("index write changed base");

   a_addr_old_idx: assert property (
      i_acc && !use_rev |=> o_mvalid && o_maddr == $past(cur_idx)
   ) else $error("address is not the old index");

   a_bitrev_addr: assert property (
      i_acc && use_rev |=> o_maddr == $past(rev_idx)
   ) else $error("bit-reversed address wrong");

   a_bcast_read_only: assert property (
      o_bcast |-> o_mread && o_pvalid && o_paddr == o_maddr
   ) else $error("broadcast on a non-read");

   a_bcast_dreg_load: assert property (
      i_acc && use_bc |=> o_bcast ##1 !o_bcast || $past(i_acc)
   ) else $error("broadcast load not flagged");

   a_simd_pair: assert property (
      i_acc && r.mode[`DAM_MB_SIMD] && !use_bc && !use_rev
      |=> o_pvalid && o_paddr == o_maddr + `DAM_PAIR_STEP
   ) else $error("simd second transfer wrong");

   a_linear_step: assert property (
      i_acc && !i_wr && (!circ || cur_len == '0)
      |=> r.idx[$past(asel)] == $past(cur_idx) + $past(cur_mod)
   ) else $error("plain post-modify wrong");

   a_wrap_bounds: assert property (
      i_acc && !i_wr && circ && cur_len != '0 && !cur_mod[`DAM_DW-1]
      && cur_idx + cur_mod >= cur_bas + cur_len
      |=> r.idx[$past(asel)] == $past(cur_idx + cur_mod - cur_len)
   ) else $error("positive wrap wrong");

   a_mode_reset: assert property (
      @(posedge i_clk) disable iff (1'b0)
      !i_nrst |=> o_mode == `DAM_MODE_RST
   ) else $error("mode not cleared by reset");

   // wraparound, base write and modifier source checks
   a_neg_wrap: assert property (
      i_acc && !i_wr && circ && cur_len != '0 && cur_mod[`DAM_DW-1]
      && cur_idx + cur_mod < cur_bas
      |=> r.idx[$past(asel)] == $past(cur_idx + cur_mod + cur_len)
   ) else $error("negative wrap wrong");

   a_zero_len: assert property (
      i_acc && !i_wr && circ && cur_len == '0
      |=> r.idx[$past(asel)] == $past(cur_idx) + $past(cur_mod)
   ) else $error("zero length still wraps");

   a_base_any_mode: assert property (
      wr_bas && !circ
      |=> r.idx[$past(wsel)] == $past(i_wdata)
   ) else $error("base write ignored index with circ off");

   a_imm_mod: assert property (
      i_acc && i_acc_imm && !i_wr && !circ
      |=> r.idx[$past(asel)] == $past(cur_idx) + $past(i_acc_ival)
   ) else $error("immediate modifier not used");

   a_mod_reg_sel: assert property (
      i_acc && !i_acc_imm && !i_wr && !circ
      |=> r.idx[$past(asel)] == $past(cur_idx) + $past(r.mdf[msel])
   ) else $error("modify register not used");

   // broadcast and read flag checks
   a_no_bcast_write: assert property (
      i_acc && !i_acc_rd
      |=> !o_bcast
   ) else $error("broadcast on a memory write");

   a_no_bcast_ureg: assert property (
      i_acc && !i_acc_dreg
      |=> !o_bcast
   ) else $error("broadcast on a universal register");

   a_bcast_simd_same: assert property (
      i_acc && use_bc && r.mode[`DAM_MB_SIMD]
      |=> o_bcast && o_paddr == o_maddr
   ) else $error("simd select changed broadcast");

   a_read_flag: assert property (
      i_acc
      |=> o_mread == $past(i_acc_rd)
   ) else $error("read flag wrong");

   // bit-reverse checks
   a_rev_keeps_idx: assert property (
      i_acc && use_rev && !i_wr && !circ
      |=> r.idx[$past(asel)] == $past(cur_idx) + $past(cur_mod)
   ) else $error("stored index was reversed");

   a_rev_only_sel: assert property (
      i_acc && asel != `DAM_BR_A_IDX && asel != `DAM_BR_B_IDX
      |=> o_maddr == $past(cur_idx)
   ) else $error("reversal on another index");

   // simd pairing, pulse and mode write checks
   a_simd_off_single: assert property (
      i_acc && !r.mode[`DAM_MB_SIMD] && !use_bc
      |=> !o_pvalid
   ) else $error("second transfer without simd");

   a_simd_odd_len: assert property (
      i_acc && r.mode[`DAM_MB_SIMD] && !use_bc && cur_len[0]
      |=> o_pvalid && o_paddr == o_maddr + `DAM_PAIR_STEP
   ) else $error("odd length pair wrong");

   a_pulse_idle: assert property (
      !i_acc
      |=> !o_mvalid && !o_pvalid && !o_bcast
   ) else $error("transfer pulse without access");

   a_rdata_idle: assert property (
      !i_rd
      |=> o_rdata == '0
   ) else $error("read data outside its cycle");

   a_mode_write: assert property (
      wr_mode
      |=> o_mode == $past(i_wdata[`DAM_MODE_W-1:0])
   ) else $error("mode write lost");
endmodule

// *** common/dam_defs.svh ***
// constants for the address-generator mode block
// assumes word-indexed register port addresses of DAM_AW bits
`ifndef DAM_DEFS_SVH
`define DAM_DEFS_SVH
`define DAM_AW        8
`define DAM_DW        32
`define DAM_NREG      16
`define DAM_SELW      4
// register groups, word index of first entry
`define DAM_OFS_IDX   8'h00
`define DAM_OFS_MOD   8'h10
`define DAM_OFS_LEN   8'h20
`define DAM_OFS_BAS   8'h30
`define DAM_OFS_MODE  8'h40
// mode control one fields
`define DAM_MB_CIRC   0
`define DAM_MB_BCA    1
`define DAM_MB_BCB    2
`define DAM_MB_BRA    3
`define DAM_MB_BRB    4
`define DAM_MB_SIMD   5
`define DAM_MODE_W    6
`define DAM_MODE_RST  6'h00
// index registers with special behaviour
`define DAM_BC_A_IDX  4'h1
`define DAM_BC_B_IDX  4'h9
`define DAM_BR_A_IDX  4'h0
`define DAM_BR_B_IDX  4'h8
`define DAM_PAIR_STEP 32'h0000_0001
`endif

// *** common/dam_pkg.sv ***
// types for the address-generator mode block
// assumes dam_defs.svh is on the include path
`include "dam_defs.svh"
package dam_pkg;
   typedef logic [`DAM_NREG-1:0][`DAM_DW-1:0] dam_bank_type;
   typedef struct packed {
      dam_bank_type             idx;
      dam_bank_type             mdf;
      dam_bank_type             len;
      dam_bank_type             bas;
      logic [`DAM_MODE_W-1:0]   mode;
      logic [`DAM_DW-1:0]       rdata;
      logic                     mvalid;
      logic                     mread;
      logic [`DAM_DW-1:0]       maddr;
      logic                     pvalid;
      logic [`DAM_DW-1:0]       paddr;
      logic                     bcast;
   } dam_state_type;
endpackage

// *** logic/dam_circ_step.sv ***
// post-modify step with circular wraparound
// assumes software keeps |modify| below length and length positive
`timescale 1ns/1ps
module dam_circ_step #(
   parameter int DW = 32
) (
   input  wire logic [DW-1:0] i_idx,   // old index
   input  wire logic [DW-1:0] i_mod,   // signed modifier
   input  wire logic [DW-1:0] i_len,   // buffer length
   input  wire logic [DW-1:0] i_bas,   // buffer base
   input  wire logic          i_circ,  // circular enable
   output logic      [DW-1:0] o_idx    // updated index
);
   logic [DW:0] sum;
   logic [DW:0] lim;
   logic        wrap_on;

   // wide sums so the end-of-buffer compare never overflows
   always_comb begin
      sum     = {1'b0, i_idx} + {1'b0, i_mod};
      lim     = {1'b0, i_bas} + {1'b0, i_len};
      wrap_on = i_circ && (i_len != '0);
      o_idx   = sum[DW-1:0];
      if (wrap_on && !i_mod[DW-1]) begin
         // past the end: pull back by one length
         if ({1'b0, sum[DW-1:0]} >= lim) begin
            o_idx = sum[DW-1:0] - i_len;
         end
      end else if (wrap_on) begin
         // below the base: push up by one length
         if (sum[DW-1:0] < i_bas) begin
            o_idx = sum[DW-1:0] + i_len;
         end
      end
   end
endmodule

// *** sim/dam_mem_model.sv ***
// far-side model: memory feeding the two element register files
// assumes transfer strobes and addresses come from dam_address_modes
`timescale 1ns/1ps
module dam_mem_model (
   input  wire logic        i_pvalid, // second transfer
   input  wire logic        i_bcast,  // same data to both
   input  wire logic [31:0] i_maddr,  // explicit address
   input  wire logic [31:0] i_paddr,  // second address
   output logic      [31:0] o_px,     // primary element load
   output logic      [31:0] o_py      // secondary element load
);
   // memory word is a scramble of its address
   always_comb begin
      o_px = i_maddr ^ 32'h5a5a_a5a5;
      o_py = ~o_px; // no second transfer: line shows junk
      if (i_bcast)
         o_py = o_px;
      else if (i_pvalid)
         o_py = i_paddr ^ 32'h5a5a_a5a5;
   end
endmodule

// *** sim/dam_address_modes_tb.sv ***
// self-checking bench for dam_address_modes
// assumes dam_defs.svh on the include path
`timescale 1ns/1ps
`include "dam_defs.svh"
module dam_address_modes_tb;
   typedef struct packed {
      logic [31:0] maddr;
      logic        pvalid;
      logic [31:0] paddr;
      logic        bcast;
      logic        mread;
   } dam_exp_type;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic i_acc = 1'b0, i_acc_gen = 1'b0, i_acc_imm = 1'b0;
   logic i_acc_rd = 1'b0, i_acc_dreg = 1'b0, rd_seen = 1'b0;
   logic o_mvalid, o_mread, o_pvalid, o_bcast;
   logic [7:0]  i_addr = 8'h00;
   logic [2:0]  i_acc_idx = 3'h0, i_acc_msel = 3'h0;
   logic [31:0] i_wdata = 32'h0, i_acc_ival = 32'h0;
   logic [31:0] o_rdata, o_maddr, o_paddr, px, py, ev;
   logic [5:0]  o_mode, r_mode = 6'h00, mode_d = 6'h00;
   logic [31:0] r_idx[16], r_mdf[16], r_len[16], r_bas[16];
   dam_exp_type q_acc[$], e;
   logic [31:0] q_rd[$];
   int n_mismatch = 0, n_compared = 0;

   dam_address_modes i_dam_address_modes (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_acc(i_acc), .i_acc_gen(i_acc_gen),
      .i_acc_idx(i_acc_idx), .i_acc_msel(i_acc_msel),
      .i_acc_imm(i_acc_imm), .i_acc_ival(i_acc_ival),
      .i_acc_rd(i_acc_rd), .i_acc_dreg(i_acc_dreg), .o_mvalid(o_mvalid),
      .o_mread(o_mread), .o_maddr(o_maddr), .o_pvalid(o_pvalid),
      .o_paddr(o_paddr), .o_bcast(o_bcast), .o_mode(o_mode));
   dam_mem_model i_dam_mem_model (.i_pvalid(o_pvalid), .i_bcast(o_bcast),
      .i_maddr(o_maddr), .i_paddr(o_paddr), .o_px(px), .o_py(py));

   // 250 MHz core clock
   always #2 i_clk = ~i_clk;

   task automatic fail(input string msg);
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one strobe cycle, the other strobes low
   task automatic drive(input logic w, r, a);
      i_wr <= w;
      i_rd <= r;
      i_acc <= a;
      @(posedge i_clk);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      case (a[7:4])
         4'h0: r_idx[a[3:0]] = d;
         4'h1: r_mdf[a[3:0]] = d;
         4'h2: r_len[a[3:0]] = d;
         4'h3: begin
            r_bas[a[3:0]] = d;
            r_idx[a[3:0]] = d;
         end
         4'h4: if (a == `DAM_OFS_MODE) r_mode <= d[5:0];
         default: ;
      endcase
      drive(1'b1, 1'b0, 1'b0);
   endtask
   // model registers follow the design's reset to zero
   task automatic clear_model();
      for (int b = 0; b < 16; b++) begin
         r_idx[b] = 32'h0;
         r_mdf[b] = 32'h0;
         r_len[b] = 32'h0;
         r_bas[b] = 32'h0;
      end
   endtask
   task automatic reg_rd(input logic [7:0] a);
      i_addr <= a;
      case (a[7:4])
         4'h0: q_rd.push_back(r_idx[a[3:0]]);
         4'h1: q_rd.push_back(r_mdf[a[3:0]]);
         4'h2: q_rd.push_back(r_len[a[3:0]]);
         4'h3: q_rd.push_back(r_bas[a[3:0]]);
         default: q_rd.push_back(a == `DAM_OFS_MODE ? {26'h0, r_mode} : 0);
      endcase
      drive(1'b0, 1'b1, 1'b0);
   endtask
   // one access: note expected transfer, then advance the model index
   task automatic acc(input logic g, input logic [2:0] x, m,
                      input logic imm, input logic [31:0] iv,
                      input logic rd, dr);
      logic [31:0] md, o, s, l;
      dam_exp_type e;
      o = r_idx[{g, x}];
      md = imm ? iv : r_mdf[{g, m}];
      l = r_len[{g, x}];
      e.maddr = o;
      if (x == 3'h0 && r_mode[g ? `DAM_MB_BRB : `DAM_MB_BRA])
         e.maddr = {<<{o}};
      e.bcast = rd && dr && x == 3'h1 && r_mode[g ? `DAM_MB_BCB : `DAM_MB_BCA];
      e.pvalid = e.bcast || r_mode[`DAM_MB_SIMD];
      e.paddr = e.bcast ? e.maddr : e.maddr + `DAM_PAIR_STEP;
      e.mread = rd;
      s = o + md;
      if (r_mode[`DAM_MB_CIRC] && l != 0) begin
         if (!md[31] && s >= r_bas[{g, x}] + l) s = s - l;
         if (md[31] && s < r_bas[{g, x}]) s = s + l;
      end
      r_idx[{g, x}] = s;
      q_acc.push_back(e);
      {i_acc_gen, i_acc_idx, i_acc_msel} <= {g, x, m};
      {i_acc_imm, i_acc_ival, i_acc_rd, i_acc_dreg} <= {imm, iv, rd, dr};
      drive(1'b0, 1'b0, 1'b1);
   endtask

   // note which edges took a read and the mode written before them
   always @(posedge i_clk) begin
      rd_seen <= i_rd && i_nrst;
      mode_d <= r_mode;
   end
   // compare settled outputs against the oldest note
   always @(negedge i_clk) if (i_nrst) begin
      n_compared++;
      if (o_mode !== mode_d) fail("mode register");
      if (rd_seen) begin
         ev = q_rd.size() ? q_rd.pop_front() : ~o_rdata;
         n_compared++;
         if (o_rdata !== ev) fail("read data");
      end else if (o_rdata !== 32'h0) begin
         fail("read data idle");
      end
      if (o_mvalid !== 1'b0) begin
         e = q_acc.size() ? q_acc.pop_front() : ~e;
         n_compared++;
         if (o_maddr !== e.maddr) fail("address");
         if ({o_mread, o_pvalid, o_bcast} !== {e.mread, e.pvalid, e.bcast})
            fail("transfer flags");
         if (e.pvalid && o_paddr !== e.paddr)
            fail("second address");
         if (e.bcast && py !== px) fail("broadcast data");
         if (e.pvalid && !e.bcast && (py ^ e.paddr) !== 32'h5a5a_a5a5)
            fail("second element data");
      end else if ({o_mread, o_pvalid, o_bcast} !== 3'b000) begin
         fail("stray transfer pulse");
      end
   end

   // watchdog well beyond the expected run
   initial begin
      #200000;
      fail("timeout");
      stop_test();
   end

   initial begin
      void'($urandom(32'hf173));
      clear_model();
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      reg_rd(`DAM_OFS_MODE);
      reg_wr(8'h7f, 32'hffff_ffff);
      reg_rd(8'h7f);
      reg_rd(`DAM_OFS_IDX + 8'h5);
      // buffers: modifiers below every nonzero length
      for (int b = 0; b < 16; b++) begin
         reg_wr(`DAM_OFS_BAS + b, 32'h1000 + b * 32'h200 + $urandom % 64);
         reg_wr(`DAM_OFS_LEN + b, b % 5 == 4 ? 0 : 16 + $urandom % 48);
         reg_wr(`DAM_OFS_MOD + b, $urandom % 31 - 15);
      end
      reg_wr(`DAM_OFS_IDX + 8'h3, 32'h5000);
      reg_rd(`DAM_OFS_BAS + 8'h3);
      for (int k = 0; k < 600; k++) begin
         if (k % 40 == 0) begin
            // circular off first, then random modes with circular on except at k % 160 == 80
            reg_wr(`DAM_OFS_MODE,
                   k ? 32'({$urandom, k % 160 != 80}) : 32'h0);
            for (int b = 0; b < 16; b++) reg_wr(`DAM_OFS_BAS + b, r_bas[b]);
            drive(1'b0, 1'b0, 1'b0);
         end
         acc(1'($urandom), 3'($urandom % 2 ? $urandom % 2 : $urandom),
             3'($urandom), 1'($urandom), $urandom % 31 - 15,
             1'($urandom), 1'($urandom));
         if ($urandom % 4 == 0) reg_rd(8'($urandom % 16));
      end
      drive(1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge i_clk);
      // second reset in mid-run: all registers and mode back to zero
      i_nrst <= 1'b0;
      r_mode <= 6'h00;
      clear_model();
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      reg_rd(`DAM_OFS_MODE);
      reg_rd(`DAM_OFS_BAS + 8'h2);
      drive(1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge i_clk);
      n_compared++;
      if (q_acc.size() || q_rd.size()) fail("results missing");
      stop_test();
   end
endmodule
